/* logic/lgbp_pkg.sv */
package lgbp_pkg;
	// register offsets
	localparam logic [7:0] PATTERN_CONFIG_ADDR      = 8'hA0;
	localparam logic [7:0] PATTERN_TIMING_A_ADDR    = 8'hA1;
	localparam logic [7:0] PATTERN_GO_STATUS_ADDR   = 8'hA2;
	localparam logic [7:0] PATTERN_TIMING_B_ADDR    = 8'hA3;
	localparam logic [7:0] PATTERN_LOOP_TIMING_ADDR = 8'hA4;
	localparam logic [7:0] PATTERN_REPEAT_LOW_ADDR  = 8'hA5;
	localparam logic [7:0] FADE_HIGH_LEVEL_ADDR     = 8'hA6;
	localparam logic [7:0] FADE_LOW_LEVEL_ADDR      = 8'hA7;
	localparam logic [7:0] SHARED_RED_COLOR_ADDR    = 8'hA8;
	localparam logic [7:0] SHARED_GREEN_COLOR_ADDR  = 8'hA9;
	localparam logic [7:0] SHARED_BLUE_COLOR_ADDR   = 8'hAA;
	localparam logic [7:0] GROUP_SELECT_LOW_ADDR    = 8'hAB;
	localparam logic [7:0] GROUP_SELECT_HIGH_ADDR   = 8'hAC;
	// pattern_config fields
	localparam int PATTERN_ENABLE_BIT      = 0;
	localparam int PATTERN_AUTO_SELECT_BIT = 1;
	localparam int RAMP_ENABLE_BIT         = 2;
	localparam int SWITCH_BIT              = 3;
	// pattern_go_status fields
	localparam int RUN_BIT                 = 0;
	localparam int RUNNING_BIT             = 1;
	localparam int DONE_BIT                = 2;
	// pattern_loop_timing fields
	localparam int LOOP_END_LSB            = 6;
	localparam int LOOP_BEGIN_LSB          = 4;
	localparam int REPEAT_HIGH_LSB         = 0;
	// group_select_high fields
	localparam int GROUP_COLOR_DISABLE_BIT = 4;
	localparam int GROUP_HIGH_LSB          = 0;
	// reset value of every register
	localparam logic [7:0] REG_RESET       = 8'h00;
	// fixed internal tick that paces ramps and phases
	localparam int TICK_NS                 = 32000;
	localparam int CLK_PERIOD_NS           = 8;
	localparam int TICK_CYCLES             = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// phase duration table, ticks per four-bit code, code 0 in the low word
	localparam logic [255:0] DUR_TABLE_DEF = {
		16'h0800, 16'h0600, 16'h0400, 16'h0300, 16'h0200, 16'h0180, 16'h0100, 16'h00C0,
		16'h0080, 16'h0060, 16'h0040, 16'h0020, 16'h0010, 16'h0008, 16'h0004, 16'h0000};
	typedef enum logic [4:0] {
		PH_IDLE = 5'h01,
		PH_RISE = 5'h02,
		PH_ON   = 5'h04,
		PH_FALL = 5'h08,
		PH_OFF  = 5'h10
	} lgbp_phase_t;
endpackage : lgbp_pkg

/* logic/lgbp_top.sv */
`timescale 1ns/1ps
//Function
//- twelve group-enable bits each put three adjacent LEDs under group control
//- low byte bits 0-7 cover LEDs 1-24, high byte bits 0-3 LEDs 25-36
//- grouped LEDs take shared brightness and red/green/blue by position in group
//- colour disable makes grouped LEDs use own colour; ungrouped use own values
//- pattern-enable bit at 1 enables the breathing controller
//- with controller on, only groups with enable bit follow controller output
//- mode bit 1 selects autonomous breathing, 0 selects manual control
//- autonomous loop runs rise, on, fall, off phases with programmed durations
//- breathing output spans low fade level up to high fade level
//- two-bit loop-begin field selects the starting phase
//- loop-end nonzero ends loop after rise, zero ends it after fall
//- twelve-bit repeat count from high nibble and low byte; zero repeats forever
//- finished repeats set done flag, cleared when host reads it
//- done flag also clears on loop restart or writing manual mode
//- writing 1 to run bit starts the autonomous pattern
//- manual output is high level with switch 1, low level with switch 0
//- with ramp enabled a switch change ramps output toward new level
//- with ramp disabled output steps at once to the new level
//- pattern enable 0 gives grouped LEDs the low fade level as brightness
module lgbp_top #(
	parameter int             NUM_CH      = 36,
	parameter int             TICK_CYC    = lgbp_pkg::TICK_CYCLES,
	parameter logic [255:0]   DUR_TABLE   = lgbp_pkg::DUR_TABLE_DEF
) (
	// clock and reset
	input  wire logic                  CLK_IN,
	input  wire logic                  RST_N_IN,
	// register port from the serial interface engine
	input  wire logic [7:0]            REG_ADDR_IN,
	input  wire logic [7:0]            REG_WDATA_IN,
	input  wire logic                  REG_WR_IN,
	input  wire logic                  REG_RD_IN,
	output logic      [7:0]            REG_RDATA_OUT,
	// per-channel individual values
	input  wire logic [NUM_CH*8-1:0]   CH_BRIGHT_IN,
	input  wire logic [NUM_CH*8-1:0]   CH_COLOR_IN,
	// resolved channel values
	output logic      [NUM_CH*8-1:0]   LED_BRIGHT_OUT,
	output logic      [NUM_CH*8-1:0]   LED_COLOR_OUT,
	output logic      [7:0]            PATTERN_LEVEL_OUT
);
	logic [1:0] rst_sync_q;
	logic       rst_n;
	logic [7:0] cfg_q, ta_q, tb_q, loop_q, rep_lo_q, high_q, low_q;
	logic [7:0] red_q, green_q, blue_q, gsel_lo_q, gsel_hi_q;
	logic       run_q, done_q;
	logic [7:0] lvl_q;
	logic [11:0] loop_cnt_q;
	logic [15:0] ph_cnt_q;
	logic [$clog2(TICK_CYC+1)-1:0] tick_cnt_q;
	logic       tick_q;
	lgbp_pkg::lgbp_phase_t state_q;

	function automatic lgbp_pkg::lgbp_phase_t phase_of(input logic [1:0] sel);
		case (sel)
			2'h0: phase_of = lgbp_pkg::PH_RISE;
			2'h1: phase_of = lgbp_pkg::PH_ON;
			2'h2: phase_of = lgbp_pkg::PH_FALL;
			default: phase_of = lgbp_pkg::PH_OFF;
		endcase
	endfunction : phase_of

	function automatic lgbp_pkg::lgbp_phase_t next_of(input lgbp_pkg::lgbp_phase_t s);
		case (s)
			lgbp_pkg::PH_RISE: next_of = lgbp_pkg::PH_ON;
			lgbp_pkg::PH_ON:   next_of = lgbp_pkg::PH_FALL;
			lgbp_pkg::PH_FALL: next_of = lgbp_pkg::PH_OFF;
			default:           next_of = lgbp_pkg::PH_RISE;
		endcase
	endfunction : next_of

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	wire        wr       = REG_WR_IN;
	wire        pat_en   = cfg_q[lgbp_pkg::PATTERN_ENABLE_BIT];
	wire        auto_md  = cfg_q[lgbp_pkg::PATTERN_AUTO_SELECT_BIT];
	wire        ramp_en  = cfg_q[lgbp_pkg::RAMP_ENABLE_BIT];
	wire        sw       = cfg_q[lgbp_pkg::SWITCH_BIT];
	wire [1:0]  beg_sel  = loop_q[lgbp_pkg::LOOP_BEGIN_LSB +: 2];
	wire [1:0]  end_sel  = loop_q[lgbp_pkg::LOOP_END_LSB +: 2];
	wire [11:0] rep_cnt  = {loop_q[lgbp_pkg::REPEAT_HIGH_LSB +: 4], rep_lo_q};
	wire [11:0] ge       = {gsel_hi_q[lgbp_pkg::GROUP_HIGH_LSB +: 4], gsel_lo_q};
	wire        col_dis  = gsel_hi_q[lgbp_pkg::GROUP_COLOR_DISABLE_BIT];
	wire        go_wr    = wr && REG_ADDR_IN == lgbp_pkg::PATTERN_GO_STATUS_ADDR;
	wire        start    = go_wr && REG_WDATA_IN[lgbp_pkg::RUN_BIT] && pat_en && auto_md;
	wire        running  = state_q != lgbp_pkg::PH_IDLE;
	wire        man_clr  = wr && REG_ADDR_IN == lgbp_pkg::PATTERN_CONFIG_ADDR
		&& !REG_WDATA_IN[lgbp_pkg::PATTERN_AUTO_SELECT_BIT];
	wire        done_rd  = REG_RD_IN && REG_ADDR_IN == lgbp_pkg::PATTERN_GO_STATUS_ADDR;
	wire [7:0]  target   = sw ? high_q : low_q;

	logic [3:0] dur_code;
	always_comb begin
		case (state_q)
			lgbp_pkg::PH_RISE: dur_code = ta_q[7:4];
			lgbp_pkg::PH_ON:   dur_code = ta_q[3:0];
			lgbp_pkg::PH_FALL: dur_code = tb_q[7:4];
			default:           dur_code = tb_q[3:0];
		endcase
	end
	wire [15:0] dur       = DUR_TABLE[{dur_code, 4'h0} +: 16];
	wire        ph_end    = running && tick_q && ph_cnt_q >= dur;
	wire        end_point = (end_sel != 2'h0) ? state_q == lgbp_pkg::PH_RISE
		: state_q == lgbp_pkg::PH_FALL;
	wire        loop_fin  = ph_end && end_point && rep_cnt != 12'h000
		&& loop_cnt_q + 12'h001 == rep_cnt;

	// register writes
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q     <= lgbp_pkg::REG_RESET;
			ta_q      <= lgbp_pkg::REG_RESET;
			tb_q      <= lgbp_pkg::REG_RESET;
			loop_q    <= lgbp_pkg::REG_RESET;
			rep_lo_q  <= lgbp_pkg::REG_RESET;
			high_q    <= lgbp_pkg::REG_RESET;
			low_q     <= lgbp_pkg::REG_RESET;
			red_q     <= lgbp_pkg::REG_RESET;
			green_q   <= lgbp_pkg::REG_RESET;
			blue_q    <= lgbp_pkg::REG_RESET;
			gsel_lo_q <= lgbp_pkg::REG_RESET;
			gsel_hi_q <= lgbp_pkg::REG_RESET;
		end else if (wr) begin
			if (REG_ADDR_IN == lgbp_pkg::PATTERN_CONFIG_ADDR)
				cfg_q <= {4'h0, REG_WDATA_IN[3:0]};
			else if (REG_ADDR_IN == lgbp_pkg::PATTERN_TIMING_A_ADDR)
				ta_q <= REG_WDATA_IN;
			else if (REG_ADDR_IN == lgbp_pkg::PATTERN_TIMING_B_ADDR)
				tb_q <= REG_WDATA_IN;
			else if (REG_ADDR_IN == lgbp_pkg::PATTERN_LOOP_TIMING_ADDR)
				loop_q <= REG_WDATA_IN;
			else if (REG_ADDR_IN == lgbp_pkg::PATTERN_REPEAT_LOW_ADDR)
				rep_lo_q <= REG_WDATA_IN;
			else if (REG_ADDR_IN == lgbp_pkg::FADE_HIGH_LEVEL_ADDR)
				high_q <= REG_WDATA_IN;
			else if (REG_ADDR_IN == lgbp_pkg::FADE_LOW_LEVEL_ADDR)
				low_q <= REG_WDATA_IN;
			else if (REG_ADDR_IN == lgbp_pkg::SHARED_RED_COLOR_ADDR)
				red_q <= REG_WDATA_IN;
			else if (REG_ADDR_IN == lgbp_pkg::SHARED_GREEN_COLOR_ADDR)
				green_q <= REG_WDATA_IN;
			else if (REG_ADDR_IN == lgbp_pkg::SHARED_BLUE_COLOR_ADDR)
				blue_q <= REG_WDATA_IN;
			else if (REG_ADDR_IN == lgbp_pkg::GROUP_SELECT_LOW_ADDR)
				gsel_lo_q <= REG_WDATA_IN;
			else if (REG_ADDR_IN == lgbp_pkg::GROUP_SELECT_HIGH_ADDR)
				gsel_hi_q <= {3'h0, REG_WDATA_IN[4:0]};
		end
	end

	// register reads, answer one cycle after the strobe
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n)
			REG_RDATA_OUT <= 8'h00;
		else if (REG_RD_IN) begin
			if (REG_ADDR_IN == lgbp_pkg::PATTERN_CONFIG_ADDR)
				REG_RDATA_OUT <= cfg_q;
			else if (REG_ADDR_IN == lgbp_pkg::PATTERN_TIMING_A_ADDR)
				REG_RDATA_OUT <= ta_q;
			else if (REG_ADDR_IN == lgbp_pkg::PATTERN_GO_STATUS_ADDR)
				REG_RDATA_OUT <= {5'h00, done_q, running, run_q};
			else if (REG_ADDR_IN == lgbp_pkg::PATTERN_TIMING_B_ADDR)
				REG_RDATA_OUT <= tb_q;
			else if (REG_ADDR_IN == lgbp_pkg::PATTERN_LOOP_TIMING_ADDR)
				REG_RDATA_OUT <= loop_q;
			else if (REG_ADDR_IN == lgbp_pkg::PATTERN_REPEAT_LOW_ADDR)
				REG_RDATA_OUT <= rep_lo_q;
			else if (REG_ADDR_IN == lgbp_pkg::FADE_HIGH_LEVEL_ADDR)
				REG_RDATA_OUT <= high_q;
			else if (REG_ADDR_IN == lgbp_pkg::FADE_LOW_LEVEL_ADDR)
				REG_RDATA_OUT <= low_q;
			else if (REG_ADDR_IN == lgbp_pkg::SHARED_RED_COLOR_ADDR)
				REG_RDATA_OUT <= red_q;
			else if (REG_ADDR_IN == lgbp_pkg::SHARED_GREEN_COLOR_ADDR)
				REG_RDATA_OUT <= green_q;
			else if (REG_ADDR_IN == lgbp_pkg::SHARED_BLUE_COLOR_ADDR)
				REG_RDATA_OUT <= blue_q;
			else if (REG_ADDR_IN == lgbp_pkg::GROUP_SELECT_LOW_ADDR)
				REG_RDATA_OUT <= gsel_lo_q;
			else if (REG_ADDR_IN == lgbp_pkg::GROUP_SELECT_HIGH_ADDR)
				REG_RDATA_OUT <= gsel_hi_q;
			else
				REG_RDATA_OUT <= 8'h00;
		end
	end

	// tick pacing ramps and phase durations
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end else begin
			tick_q     <= tick_cnt_q == ($bits(tick_cnt_q))'(TICK_CYC - 1);
			tick_cnt_q <= (tick_cnt_q == ($bits(tick_cnt_q))'(TICK_CYC - 1)) ? '0
				: tick_cnt_q + 1'b1;
		end
	end

	// autonomous loop sequencing
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			state_q    <= lgbp_pkg::PH_IDLE;
			ph_cnt_q   <= 16'h0000;
			loop_cnt_q <= 12'h000;
			run_q      <= 1'b0;
		end else if (start) begin
			state_q    <= phase_of(beg_sel);
			ph_cnt_q   <= 16'h0000;
			loop_cnt_q <= 12'h000;
			run_q      <= 1'b1;
		end else if (!pat_en || !auto_md || (go_wr && !REG_WDATA_IN[lgbp_pkg::RUN_BIT])) begin
			state_q <= lgbp_pkg::PH_IDLE;
			run_q   <= 1'b0;
		end else if (loop_fin) begin
			state_q <= lgbp_pkg::PH_IDLE;
			run_q   <= 1'b0;
		end else if (ph_end) begin
			ph_cnt_q <= 16'h0000;
			if (end_point) begin
				loop_cnt_q <= loop_cnt_q + 12'h001;
				state_q    <= phase_of(beg_sel);
			end else
				state_q <= next_of(state_q);
		end else if (tick_q && running)
			ph_cnt_q <= ph_cnt_q + 16'h0001;
	end

	// set wins over every clear
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n)
			done_q <= 1'b0;
		else if (loop_fin)
			done_q <= 1'b1;
		else if (done_rd || start || man_clr)
			done_q <= 1'b0;
	end

	// controller level
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n)
			lvl_q <= 8'h00;
		else if (!auto_md) begin
			if (!ramp_en)
				lvl_q <= target;
			else if (tick_q && lvl_q < target)
				lvl_q <= lvl_q + 8'h01;
			else if (tick_q && lvl_q > target)
				lvl_q <= lvl_q - 8'h01;
		end else if (start)
			lvl_q <= (phase_of(beg_sel) == lgbp_pkg::PH_RISE
				|| phase_of(beg_sel) == lgbp_pkg::PH_OFF) ? low_q : high_q;
		else if (running) begin
			case (state_q)
				lgbp_pkg::PH_RISE: if (tick_q && lvl_q < high_q) lvl_q <= lvl_q + 8'h01;
				lgbp_pkg::PH_FALL: if (tick_q && lvl_q > low_q) lvl_q <= lvl_q - 8'h01;
				lgbp_pkg::PH_ON:   lvl_q <= high_q;
				default:           lvl_q <= low_q;
			endcase
		end
	end

	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n)
			PATTERN_LEVEL_OUT <= 8'h00;
		else
			PATTERN_LEVEL_OUT <= lvl_q;
	end

	// per-channel source selection
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			LED_BRIGHT_OUT <= '0;
			LED_COLOR_OUT  <= '0;
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (ge[c / 3]) begin
					LED_BRIGHT_OUT[c*8 +: 8] <= pat_en ? lvl_q : low_q;
					if (col_dis)
						LED_COLOR_OUT[c*8 +: 8] <= CH_COLOR_IN[c*8 +: 8];
					else
						LED_COLOR_OUT[c*8 +: 8] <= (c % 3 == 0) ? red_q
							: (c % 3 == 1) ? green_q : blue_q;
				end else begin
					LED_BRIGHT_OUT[c*8 +: 8] <= CH_BRIGHT_IN[c*8 +: 8];
					LED_COLOR_OUT[c*8 +: 8]  <= CH_COLOR_IN[c*8 +: 8];
				end
			end
		end
	end

	// checks
	a_done_set: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		loop_fin && !start |=> done_q && state_q == lgbp_pkg::PH_IDLE)
		else $error("done flag not set at loop finish");
	a_done_rdclr: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		(done_rd || man_clr) && !loop_fin |=> !done_q)
		else $error("done flag not cleared");
	a_forever_run: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		rep_cnt == 12'h000 && ph_end && end_point && pat_en && auto_md && !go_wr
		|=> run_q && state_q == phase_of($past(beg_sel)))
		else $error("zero repeat count finished");
	a_go_begin: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		start |=> state_q == phase_of($past(beg_sel)) && run_q)
		else $error("start did not enter begin phase");
	a_end_rise: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		ph_end && !loop_fin && end_sel != 2'h0 && state_q == lgbp_pkg::PH_RISE && !start
		&& pat_en && auto_md && !go_wr |=> state_q == phase_of($past(beg_sel)))
		else $error("loop did not wrap after rise");
	a_step_level: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		!auto_md && !ramp_en ##1 !auto_md && !ramp_en |-> lvl_q == $past(target))
		else $error("manual level not stepped");
	a_ramp_hold: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		!auto_md && ramp_en && !tick_q |=> $stable(lvl_q))
		else $error("ramp moved without tick");
	a_ramp_step: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		!auto_md && ramp_en && tick_q && lvl_q < target |=> lvl_q == $past(lvl_q) + 8'h01)
		else $error("ramp step wrong");
	a_group_out: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		ge[0] && pat_en |=> LED_BRIGHT_OUT[7:0] == $past(lvl_q))
		else $error("grouped brightness not from controller");
	a_group_col: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		ge[0] && !col_dis |=> LED_COLOR_OUT[15:8] == $past(green_q))
		else $error("grouped colour not shared");
endmodule : lgbp_top

/* testbench/lgbp_host_model.sv */
`timescale 1ns/1ps
// host side of the decoded register port; one strobe per access
module lgbp_host_model (
	// clock
	input  wire logic       clk_in,
	// register port toward the device
	output logic      [7:0] addr_out,
	output logic      [7:0] wdata_out,
	output logic            wr_out,
	output logic            rd_out,
	input  wire logic [7:0] rdata_in
);
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end

	// released lines show the inverse so a stale value is never mistaken for a live one
	task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk_in);
		addr_out <= addr;
		wdata_out <= data;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		addr_out <= ~addr;
		wdata_out <= ~data;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clk_in);
		addr_out <= addr;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		addr_out <= ~addr;
		@(posedge clk_in);
		data = rdata_in;
	endtask : reg_read
endmodule : lgbp_host_model

/* testbench/test_led_group_breathing_pattern.sv */
`timescale 1ns/1ps
module test_led_group_breathing_pattern;
	logic         clk;
	logic         rst_n;
	logic [7:0]   addr;
	logic [7:0]   wdata;
	logic         wr;
	logic         rd;
	logic [7:0]   rdata;
	logic [287:0] ch_bright;
	logic [287:0] ch_color;
	logic [287:0] led_bright;
	logic [287:0] led_color;
	logic [7:0]   level;
	logic [7:0]   d;
	int           error_cnt = 0;
	int           n_tests = 0;
	int           cyc = 0;
	int           el;

	// short tick keeps every phase and ramp within a few hundred cycles
	lgbp_top #(.TICK_CYC(4)) uut (
		.CLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
		.REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .CH_BRIGHT_IN(ch_bright),
		.CH_COLOR_IN(ch_color), .LED_BRIGHT_OUT(led_bright), .LED_COLOR_OUT(led_color),
		.PATTERN_LEVEL_OUT(level));
	lgbp_host_model host (.clk_in(clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
		.rd_out(rd), .rdata_in(rdata));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;

	task automatic check(input logic [7:0] seen, input logic [7:0] expd);
		n_tests++;
		if (seen !== expd) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expd);
		end
	endtask : check

	task automatic report_and_stop();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop

	task automatic timed_out();
		check(8'h00, 8'hFF);
		report_and_stop();
	endtask : timed_out

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask : idle

	task automatic wait_level(input logic [7:0] target, input int bound);
		for (int i = 0; i < bound; i++) begin
			@(posedge clk);
			if (level === target) return;
		end
		timed_out();
	endtask : wait_level

	// polling clears the done flag, so the status seen at completion is checked here
	task automatic wait_done(output int elapsed);
		int t0;
		t0 = cyc;
		for (int i = 0; i < 200; i++) begin
			host.reg_read(8'hA2, d);
			if (d[lgbp_pkg::DONE_BIT] === 1'b1) begin
				elapsed = cyc - t0;
				check(d, 8'h04);
				return;
			end
		end
		timed_out();
	endtask : wait_done

	task automatic check_channels(input logic [11:0] ge, input logic dis, input logic [7:0] gb);
		for (int c = 0; c < 36; c++) begin
			check(led_bright[c*8+:8], ge[c/3] ? gb : ch_bright[c*8+:8]);
			check(led_color[c*8+:8], (ge[c/3] && !dis) ? 8'(8'h11 * (c % 3 + 1))
				: ch_color[c*8+:8]);
		end
	endtask : check_channels

	task automatic test_registers();
		for (int a = 8'hA0; a <= 8'hAC; a++) begin
			host.reg_read(8'(a), d);
			check(d, lgbp_pkg::REG_RESET);
		end
		host.reg_write(8'hA0, 8'hF0);
		host.reg_read(8'hA0, d);
		check(d, 8'h00);
		host.reg_write(8'hAC, 8'hE0);
		host.reg_read(8'hAC, d);
		check(d, 8'h00);
		host.reg_write(8'hB0, 8'hFF);
		host.reg_read(8'hB0, d);
		check(d, 8'h00);
	endtask : test_registers

	// shared values first, then the group selection
	task automatic test_groups();
		host.reg_write(8'hA8, 8'h11);
		host.reg_write(8'hA9, 8'h22);
		host.reg_write(8'hAA, 8'h33);
		host.reg_write(8'hA6, 8'h60);
		host.reg_write(8'hA7, 8'h20);
		host.reg_write(8'hAB, 8'h81);
		host.reg_write(8'hAC, 8'h08);
		idle(3);
		check_channels(12'h881, 1'b0, 8'h20);
		host.reg_write(8'hAC, 8'h18);
		idle(3);
		check_channels(12'h881, 1'b1, 8'h20);
		host.reg_write(8'hAC, 8'h08);
	endtask : test_groups

	task automatic test_manual();
		host.reg_write(8'hA0, 8'h09);
		idle(3);
		check(level, 8'h60);
		check_channels(12'h881, 1'b0, 8'h60);
		host.reg_write(8'hA0, 8'h01);
		idle(3);
		check(level, 8'h20);
		host.reg_write(8'hA0, 8'h0D);
		idle(40);
		check({7'h00, level >= 8'h27 && level <= 8'h2C}, 8'h01);
		wait_level(8'h60, 400);
		host.reg_write(8'hA0, 8'h05);
		idle(12);
		check({7'h00, level < 8'h60 && level > 8'h5A}, 8'h01);
		wait_level(8'h20, 400);
	endtask : test_manual

	// begin at rise, end after fall, two loops
	task automatic test_auto_repeat();
		host.reg_write(8'hA1, 8'h11);
		host.reg_write(8'hA3, 8'h11);
		host.reg_write(8'hA4, 8'h00);
		host.reg_write(8'hA5, 8'h02);
		// park the level high so the start value at rise is visible
		host.reg_write(8'hA0, 8'h09);
		host.reg_write(8'hA0, 8'h07);
		host.reg_write(8'hA2, 8'h01);
		idle(2);
		check(level, 8'h20);
		wait_level(8'h60, 200);
		wait_done(el);
		check({7'h00, el >= 80 && el <= 140}, 8'h01);
		host.reg_read(8'hA2, d);
		check(d, 8'h00);
	endtask : test_auto_repeat

	// begin at fall, end after rise: fall, off and rise before the count moves
	task automatic test_auto_begin_end();
		host.reg_write(8'hA4, 8'h60);
		host.reg_write(8'hA5, 8'h02);
		host.reg_write(8'hA2, 8'h01);
		idle(2);
		check(level, 8'h60);
		wait_done(el);
		check({7'h00, el >= 100 && el <= 140}, 8'h01);
		host.reg_write(8'hA2, 8'h01);
		idle(140);
		host.reg_write(8'hA2, 8'h01);
		host.reg_read(8'hA2, d);
		check(d, 8'h03);
		idle(140);
		host.reg_write(8'hA0, 8'h05);
		host.reg_read(8'hA2, d);
		check(d, 8'h00);
	endtask : test_auto_begin_end

	task automatic test_forever();
		host.reg_write(8'hA4, 8'h00);
		host.reg_write(8'hA5, 8'h00);
		host.reg_write(8'hA0, 8'h07);
		host.reg_write(8'hA2, 8'h01);
		idle(400);
		host.reg_read(8'hA2, d);
		check(d, 8'h03);
		host.reg_write(8'hA2, 8'h00);
		host.reg_read(8'hA2, d);
		check(d, 8'h00);
	endtask : test_forever

	initial begin
		rst_n = 1'b0;
		for (int c = 0; c < 36; c++) begin
			ch_bright[c*8+:8] = 8'(8'h40 + c);
			ch_color[c*8+:8] = 8'(8'hC0 + c);
		end
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		idle(4);
		test_registers();
		test_groups();
		test_manual();
		test_auto_repeat();
		test_auto_begin_end();
		test_forever();
		report_and_stop();
	end
endmodule : test_led_group_breathing_pattern
